// file: design/jtd_defs.svh
// offsets, field positions, reset values and codes of the debug port
`ifndef JTD_DEFS_SVH
`define JTD_DEFS_SVH
`define JTD_ADDR_INSTR   32'hFFFF_FCB0
`define JTD_ADDR_STATUS  32'hFFFF_FCB2
`define JTD_ADDR_DATA_HI 32'hFFFF_FCB4
`define JTD_ADDR_DATA_LO 32'hFFFF_FCB6
`define JTD_INSTR_RST    16'hE000
`define JTD_STATUS_RST   16'h0701
`define JTD_STATUS_FIXED 16'h0700
`define JTD_TS_MSB       15
`define JTD_TS_LSB       12
`define JTD_IR_LEN       4
`define JTD_DR_LEN       32
`define JTD_ID_LEN       32
`define JTD_BSR_LEN      330
`define JTD_FLAG_BIT     0
`define JTD_OP_EXTEST    4'h0
`define JTD_OP_CLAMP     4'h2
`define JTD_OP_HIGHZ     4'h3
`define JTD_OP_SAMPLE    4'h4
`define JTD_OP_DBGINT    4'hA
`define JTD_OP_IDCODE    4'hE
`define JTD_OP_BYPASS    4'hF
`endif

// file: design/jtd_pkg.sv
// types shared by the debug port design
package jtd_pkg;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } jtd_size_e;
    typedef enum logic [15:0] {
        ST_TLR   = 16'h0001,
        ST_RTI   = 16'h0002,
        ST_SELDR = 16'h0004,
        ST_CAPDR = 16'h0008,
        ST_SHDR  = 16'h0010,
        ST_EX1DR = 16'h0020,
        ST_PADR  = 16'h0040,
        ST_EX2DR = 16'h0080,
        ST_UPDR  = 16'h0100,
        ST_SELIR = 16'h0200,
        ST_CAPIR = 16'h0400,
        ST_SHIR  = 16'h0800,
        ST_EX1IR = 16'h1000,
        ST_PAIR  = 16'h2000,
        ST_EX2IR = 16'h4000,
        ST_UPIR  = 16'h8000
    } jtd_state_e;
endpackage : jtd_pkg

// file: design/jtd_top.sv
// user_debug_port: test access port, debug registers and cpu register access
// Notes on behaviour
// R01 - mode select is sampled on each test clock rise and steps the controller
// R02 - data input is sampled on each test clock rise into the selected register
// R03 - undriven mode select and data input read as logic 1
// R04 - data output follows the test clock and floats when nothing shifts out
// R05 - test reset low initializes the port at once, no clock edge needed
// R06 - only test reset initializes debug registers; system reset leaves them alone
// R07 - instruction register is 16 bits, cpu read-only, loaded only serially
// R08 - instruction has 4 valid bits; only the last 4 shifted in are kept
// R09 - codes: 0 extest, 2 clamp, 3 highz, 4 sample, A interrupt, E id, F bypass
// R10 - tester never loads a reserved instruction code
// R11 - bypass mode puts one shift bit between data input and output
// R12 - sample and extest modes put the 330-bit boundary chain in the path
// R13 - id mode shifts out a fixed 32-bit code that takes no serial input
// R14 - instruction, status and data shift out; status takes no serial input
// R15 - cpu reaches instruction, status, data with 8, 16 or 32 bit accesses
// R16 - selecting the debug interrupt instruction raises an interrupt request
// R17 - only bypass is a supported test mode; others are listed only
// R18 - status bit 0 is 1 while a data transfer runs, 0 once ended
// R19 - data register shifts in at its msb, out at its lsb, keeps last 32
// R20 - status shift gives the transfer flag first, then a reserved bit
// R21 - controller is the standard sixteen state machine
// R22 - data output changes on the falling clock edge, driven only while shifting
`include "jtd_defs.svh"
module jtd_top #(
    parameter logic [31:0] ID_CODE = 32'h1234_5001  // arbitrary value
) (
    input  wire logic              CLK,
    input  wire logic              RESET,
    input  wire logic              TCK,
    input  wire logic              TRST_N,
    input  wire logic              TMS,
    input  wire logic              TMS_DRIVEN,
    input  wire logic              TDI,
    input  wire logic              TDI_DRIVEN,
    output logic                   TDO,
    output logic                   TDO_OE,
    input  wire logic [31:0]       CPU_ADDR,
    input  jtd_pkg::jtd_size_e     CPU_SIZE,
    input  wire logic              CPU_RD,
    input  wire logic              CPU_WR,
    input  wire logic [31:0]       CPU_WDATA,
    output logic [31:0]            CPU_RDATA,
    output logic                   CPU_ACK,
    output logic                   INTR_REQ
);
    import jtd_pkg::*;

    localparam logic [31:0] BASE = `JTD_ADDR_INSTR;

    // ---------------- test clock domain ----------------
    jtd_state_e                  st_r;
    jtd_state_e                  st_nxt;
    logic [`JTD_IR_LEN-1:0]      instr_r;
    logic [`JTD_IR_LEN-1:0]      ir_sh_r;
    logic [`JTD_DR_LEN-1:0]      dr_r;
    logic [`JTD_ID_LEN-1:0]      id_sh_r;
    logic [`JTD_BSR_LEN-1:0]     bsr_r;
    logic                        bp_r;
    logic                        ir_tgl_r;
    logic                        dup_tgl_r;
    logic                        dcap_tgl_r;
    logic [2:0]                  t_wr_s_r;
    logic [1:0]                  t_flag_s_r;
    logic                        tdo_r;
    logic                        oe_r;
    // cpu clock registers; the test clock side reads dc_r after a toggle handshake and flag_r through two synchronizer stages
    logic                        flag_r;
    logic                        wr_tgl_r;
    logic [`JTD_DR_LEN-1:0]      dc_r;

    wire tms_eff  = TMS | ~TMS_DRIVEN;  // R03
    wire tdi_eff  = TDI | ~TDI_DRIVEN;  // R03
    wire sel_bsr  = (instr_r == `JTD_OP_EXTEST) || (instr_r == `JTD_OP_SAMPLE);  // R12
    wire sel_id   = (instr_r == `JTD_OP_IDCODE);
    wire sel_data = (instr_r == `JTD_OP_DBGINT);
    // clamp, highz and reserved codes fall back to bypass; only bypass is guaranteed
    wire sel_bp   = !sel_bsr && !sel_id && !sel_data;  // R17
    wire flag_t   = t_flag_s_r[1];
    wire cpu_load = t_wr_s_r[2] ^ t_wr_s_r[1];
    wire sh_dr    = (st_r == ST_SHDR);
    wire sh_ir    = (st_r == ST_SHIR);
    wire shifting = sh_dr || sh_ir;
    wire cap_dr   = (st_r == ST_CAPDR);
    wire upd_dr   = (st_r == ST_UPDR);
    wire dr_bit   = sel_bsr  ? bsr_r[0] :
                    sel_id   ? id_sh_r[0] :
                    sel_data ? dr_r[0] : bp_r;
    wire tdo_mux  = sh_ir ? ir_sh_r[0] : dr_bit;

    always_comb begin  // R21
        case (st_r)
            ST_TLR:   st_nxt = tms_eff ? ST_TLR   : ST_RTI;
            ST_RTI:   st_nxt = tms_eff ? ST_SELDR : ST_RTI;
            ST_SELDR: st_nxt = tms_eff ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: st_nxt = tms_eff ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  st_nxt = tms_eff ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: st_nxt = tms_eff ? ST_UPDR  : ST_PADR;
            ST_PADR:  st_nxt = tms_eff ? ST_EX2DR : ST_PADR;
            ST_EX2DR: st_nxt = tms_eff ? ST_UPDR  : ST_SHDR;
            ST_UPDR:  st_nxt = tms_eff ? ST_SELDR : ST_RTI;
            ST_SELIR: st_nxt = tms_eff ? ST_TLR   : ST_CAPIR;
            ST_CAPIR: st_nxt = tms_eff ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  st_nxt = tms_eff ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: st_nxt = tms_eff ? ST_UPIR  : ST_PAIR;
            ST_PAIR:  st_nxt = tms_eff ? ST_EX2IR : ST_PAIR;
            ST_EX2IR: st_nxt = tms_eff ? ST_UPIR  : ST_SHIR;
            ST_UPIR:  st_nxt = tms_eff ? ST_SELDR : ST_RTI;
            default:  st_nxt = ST_TLR;
        endcase
    end

    always_ff @(posedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin  // R05 R06
            st_r <= ST_TLR;
        end else begin
            st_r <= st_nxt;  // R01
        end
    end

    always_ff @(posedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin  // R05
            instr_r <= `JTD_OP_IDCODE;
            ir_sh_r <= `JTD_OP_IDCODE;
        end else begin
            if (st_r == ST_CAPIR) begin
                ir_sh_r <= {instr_r[3:2], 1'b0, flag_t};  // R14 R20
            end else if (sh_ir) begin
                ir_sh_r <= {tdi_eff, ir_sh_r[3:1]};  // R02 R08
            end
            if (st_r == ST_TLR) begin
                instr_r <= `JTD_OP_IDCODE;
            end else if (st_r == ST_UPIR) begin
                instr_r <= ir_sh_r;  // R07 R08 R09
            end
        end
    end

    // data, chain and id shifters keep contents across test reset
    always_ff @(posedge TCK) begin
        if (cpu_load) begin
            dr_r <= dc_r;  // dc_r is stable for two test clocks after the toggle
        end else if (sh_dr && sel_data) begin
            dr_r <= {tdi_eff, dr_r[`JTD_DR_LEN-1:1]};  // R19 R14
        end
        if (sh_dr && sel_bsr) begin
            bsr_r <= {tdi_eff, bsr_r[`JTD_BSR_LEN-1:1]};  // R12
        end
        if (cap_dr && sel_id) begin
            id_sh_r <= ID_CODE;  // R13
        end else if (sh_dr && sel_id) begin
            id_sh_r <= {1'b0, id_sh_r[`JTD_ID_LEN-1:1]};  // R13
        end
    end

    always_ff @(posedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin
            bp_r       <= 1'b0;
            ir_tgl_r   <= 1'b0;
            dup_tgl_r  <= 1'b0;
            dcap_tgl_r <= 1'b0;
            t_wr_s_r   <= 3'h0;
            t_flag_s_r <= 2'h3;
        end else begin
            bp_r       <= cap_dr ? 1'b0 : ((sh_dr && sel_bp) ? tdi_eff : bp_r);  // R11
            ir_tgl_r   <= ir_tgl_r ^ (st_r == ST_UPIR);
            dup_tgl_r  <= dup_tgl_r ^ (upd_dr && sel_data);
            dcap_tgl_r <= dcap_tgl_r ^ (cap_dr && sel_data);
            t_wr_s_r   <= {t_wr_s_r[1:0], wr_tgl_r};
            t_flag_s_r <= {t_flag_s_r[0], flag_r};
        end
    end

    // falling edge launch gives the tester a half period of setup
    always_ff @(negedge TCK or negedge TRST_N) begin
        if (!TRST_N) begin
            tdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            tdo_r <= tdo_mux;  // R22 R04
            oe_r  <= shifting;  // R22 R04
        end
    end

    assign TDO    = tdo_r;
    assign TDO_OE = oe_r;

    // ---------------- cpu clock domain ----------------
    logic [1:0]                  rs_r;
    logic [2:0]                  ir_s_r;
    logic [2:0]                  up_s_r;
    logic [2:0]                  cap_s_r;
    logic [1:0]                  irq_s_r;
    logic [`JTD_IR_LEN-1:0]      instr_c_r;
    logic [31:0]                 rdata_r;
    logic                        ack_r;
    logic [15:0]                 wd_hw [4];
    logic [15:0]                 rd_hw [4];
    logic [7:0]                  we_b;

    wire c_rst_n   = rs_r[1];
    wire ir_ev     = ir_s_r[2] ^ ir_s_r[1];
    wire dup_ev    = up_s_r[2] ^ up_s_r[1];
    wire dcap_ev   = cap_s_r[2] ^ cap_s_r[1];
    wire hit       = (CPU_ADDR[31:3] == BASE[31:3]);
    wire cpu_wr_en = CPU_WR && hit;
    wire [1:0] hw_idx = CPU_ADDR[2:1];
    wire [15:0] status_val = `JTD_STATUS_FIXED | {15'h0000, flag_r};  // R18

    // halfword lanes, big-endian: even byte address is the high byte
    for (genvar h = 0; h < 4; h++) begin : g_lane
        localparam logic [1:0] HW = 2'(h);
        wire sel = (CPU_SIZE == SZ_LONG) ? (hw_idx[1] == HW[1]) : (hw_idx == HW);
        wire hi  = (CPU_SIZE != SZ_BYTE) || !CPU_ADDR[0];
        wire lo  = (CPU_SIZE != SZ_BYTE) || CPU_ADDR[0];
        assign we_b[2*h+1] = cpu_wr_en && sel && hi;  // R15
        assign we_b[2*h]   = cpu_wr_en && sel && lo;  // R15
        assign wd_hw[h] = (CPU_SIZE == SZ_LONG) ?
                          (HW[0] ? CPU_WDATA[15:0] : CPU_WDATA[31:16]) :
                          (CPU_SIZE == SZ_WORD) ? CPU_WDATA[15:0] : {2{CPU_WDATA[7:0]}};
    end

    assign rd_hw[0] = {instr_c_r, 12'h000};  // R07
    assign rd_hw[1] = status_val;
    assign rd_hw[2] = dc_r[31:16];
    assign rd_hw[3] = dc_r[15:0];

    wire [15:0] rd_sel = rd_hw[hw_idx];
    wire [31:0] rd_val = !hit ? 32'h0000_0000 :
                         (CPU_SIZE == SZ_LONG) ?
                         (hw_idx[1] ? {rd_hw[2], rd_hw[3]} : {rd_hw[0], rd_hw[1]}) :
                         (CPU_SIZE == SZ_WORD) ? {16'h0000, rd_sel} :
                         {24'h00_0000, (CPU_ADDR[0] ? rd_sel[7:0] : rd_sel[15:8])};  // R15

    wire [31:0] dc_mrg = {we_b[5] ? wd_hw[2][15:8] : dc_r[31:24],
                          we_b[4] ? wd_hw[2][7:0]  : dc_r[23:16],
                          we_b[7] ? wd_hw[3][15:8] : dc_r[15:8],
                          we_b[6] ? wd_hw[3][7:0]  : dc_r[7:0]};
    wire dc_written = |we_b[7:4];

    // test reset reaches this domain asynchronously, released on CLK
    always_ff @(posedge CLK or negedge TRST_N) begin
        if (!TRST_N) begin
            rs_r <= 2'h0;
        end else begin
            rs_r <= {rs_r[0], 1'b1};
        end
    end

    always_ff @(posedge CLK or negedge c_rst_n) begin
        if (!c_rst_n) begin  // R06
            ir_s_r    <= 3'h0;
            up_s_r    <= 3'h0;
            cap_s_r   <= 3'h0;
            irq_s_r   <= 2'h0;
            instr_c_r <= `JTD_OP_IDCODE;
            flag_r    <= 1'b1;
            wr_tgl_r  <= 1'b0;
        end else begin
            ir_s_r    <= {ir_s_r[1:0], ir_tgl_r};
            up_s_r    <= {up_s_r[1:0], dup_tgl_r};
            cap_s_r   <= {cap_s_r[1:0], dcap_tgl_r};
            // decode the cpu-side copy; a decode of the test clock word could glitch here
            irq_s_r   <= {irq_s_r[0], instr_c_r == `JTD_OP_DBGINT};  // R16
            instr_c_r <= ir_ev ? instr_r : instr_c_r;  // R07
            wr_tgl_r  <= wr_tgl_r ^ (dc_written && !dup_ev);
            // transfer start beats a cpu write of the flag in the same cycle
            if (dcap_ev) begin
                flag_r <= 1'b1;  // R18
            end else if (dup_ev) begin
                flag_r <= 1'b0;  // R18
            end else if (we_b[2]) begin
                flag_r <= wd_hw[1][`JTD_FLAG_BIT];
            end
        end
    end

    // serial update wins over a cpu write in the same cycle
    always_ff @(posedge CLK) begin
        dc_r <= dup_ev ? dr_r : dc_mrg;  // R19
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_r <= 32'h0000_0000;
            ack_r   <= 1'b0;
        end else begin
            rdata_r <= CPU_RD ? rd_val : rdata_r;
            ack_r   <= CPU_RD || CPU_WR;
        end
    end

    assign CPU_RDATA = rdata_r;
    assign CPU_ACK   = ack_r;
    assign INTR_REQ  = irq_s_r[1];  // R16

    // ---------------- checks ----------------
    a_tms_reset: assert property (  // R01
        @(posedge TCK) disable iff (!TRST_N) tms_eff [*5] |=> st_r == ST_TLR)
        else $error("five mode select highs did not reach reset state");
    a_ir_update: assert property (  // R08
        @(posedge TCK) disable iff (!TRST_N) st_r == ST_UPIR |=> instr_r == $past(ir_sh_r))
        else $error("instruction not taken from last four shifted bits");
    a_ir_capture: assert property (  // R20
        @(posedge TCK) disable iff (!TRST_N)
        st_r == ST_CAPIR |=> ir_sh_r[1:0] == {1'b0, $past(flag_t)})
        else $error("status shift does not start with flag then reserved");
    a_bypass_path: assert property (  // R11
        @(posedge TCK) disable iff (!TRST_N) (sh_dr && sel_bp) |=> bp_r == $past(tdi_eff))
        else $error("bypass bit did not take data input");
    a_dr_shift: assert property (  // R19
        @(posedge TCK) disable iff (!TRST_N) (sh_dr && sel_data && !cpu_load)
        |=> dr_r == {$past(tdi_eff), $past(dr_r[31:1])})
        else $error("data register shift direction wrong");
    a_id_capture: assert property (  // R13
        @(posedge TCK) disable iff (!TRST_N) (cap_dr && sel_id) |=> id_sh_r == ID_CODE)
        else $error("id code not captured");
    a_tdo_float: assert property (  // R04
        @(posedge TCK) disable iff (!TRST_N) TDO_OE == shifting)
        else $error("data output enable outside shift states");
    a_flag_busy: assert property (  // R18
        @(posedge CLK) disable iff (!c_rst_n) dcap_ev |=> flag_r ##1 (flag_r || dup_ev))
        else $error("transfer flag not set at transfer start");
    a_status_read: assert property (  // R15
        @(posedge CLK) disable iff (RESET || !c_rst_n)
        (CPU_RD && hit && CPU_SIZE == SZ_WORD && hw_idx == 2'h1)
        |=> CPU_RDATA == {16'h0000, $past(status_val)})
        else $error("status word read wrong");
    a_instr_ro: assert property (  // R07
        @(posedge CLK) disable iff (!c_rst_n) (cpu_wr_en && !ir_ev) |=> $stable(instr_c_r))
        else $error("cpu write changed instruction");
    c_bypass: cover property (@(posedge TCK) disable iff (!TRST_N) sh_dr && sel_bp);
    c_data_upd: cover property (@(posedge CLK) disable iff (!c_rst_n) dup_ev);
    c_cpu_data: cover property (@(posedge CLK) disable iff (!c_rst_n) dc_written);
    c_irq: cover property (@(posedge CLK) disable iff (!c_rst_n) $rose(INTR_REQ));
endmodule : jtd_top

// file: verif/jtd_probe.sv
// probe model: drives the test pins and collects the serial output
module jtd_probe (
    output logic      tck,
    output logic      trst_n,
    output logic      tms,
    output logic      tms_drv,
    output logic      tdi,
    output logic      tdi_drv,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        tck = 1'b0;
        trst_n = 1'b0;
        tms = 1'b1;
        tms_drv = 1'b1;
        tdi = 1'b0;
        tdi_drv = 1'b1;
    end
    // one 32 ns period; the clock rests low between frames
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = tdi_drv ? d : ~tdi;  // a released line toggles so only the pull-up gives a 1
        #16;
        q = tdo_oe ? tdo : 1'bx;   // a floating output never passes for data
        tck = 1'b1;
        #16;
        tck = 1'b0;
    endtask : step
    task automatic idle(input int n);
        logic q;
        repeat (n) step(1'b0, 1'b0, q);
    endtask : idle
    task automatic set_pins(input logic rst_n, input logic drv);
        trst_n = rst_n;
        tdi_drv = drv;
    endtask : set_pins
    // hold test reset over two clocks, then settle in run-test/idle
    task automatic test_reset();
        logic q;
        trst_n = 1'b0;
        repeat (2) step(1'b1, 1'b0, q);
        trst_n = 1'b1;
        step(1'b0, 1'b0, q);
    endtask : test_reset
    // idle to idle scan, lsb first; only documented codes are loaded
    task automatic scan(input logic ir, input int n, input logic [339:0] din,
                        output logic [339:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b0, q);
        if (ir)
            step(1'b1, 1'b0, q);
        repeat (2) step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask : scan
endmodule : jtd_probe

// file: verif/jtd_top_tb.sv
// self-checking bench for the debug port
module jtd_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import jtd_pkg::*;
    localparam logic [31:0] ID_VAL   = 32'h5A3C_0F01;  // arbitrary value
    localparam logic [31:0] DATA_IN  = 32'hA5C3_1E96;
    localparam logic [31:0] DATA_OUT = 32'h1234_5678;
    typedef struct {
        logic [31:0] addr;
        jtd_size_e   size;
        logic [31:0] exp;
    } jtd_row_s;
    logic          clk, reset, tck, trst_n, tms, tms_drv, tdi, tdi_drv, tdo, tdo_oe;
    logic          cpu_rd, cpu_wr, cpu_ack, intr_req, q_bit;
    logic [31:0]   cpu_addr, cpu_wdata, cpu_rdata, rd;
    logic [339:0]  dout;
    jtd_size_e     cpu_size;
    int            err_total, n_compared;
    jtd_row_s      rows [7] = '{
        '{32'hFFFF_FCB0, SZ_WORD, 32'h0000_E000},
        '{32'hFFFF_FCB2, SZ_WORD, 32'h0000_0701},
        '{32'hFFFF_FCB0, SZ_LONG, 32'hE000_0701},
        '{32'hFFFF_FCB0, SZ_BYTE, 32'h0000_00E0},
        '{32'hFFFF_FCB1, SZ_BYTE, 32'h0000_0000},
        '{32'hFFFF_FCB3, SZ_BYTE, 32'h0000_0001},
        '{32'hFFFF_FCB8, SZ_WORD, 32'h0000_0000}
    };
    logic [3:0]    codes [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'hA, 4'hE, 4'hF};

    jtd_top #(.ID_CODE(ID_VAL)) dut (
        .CLK(clk), .RESET(reset), .TCK(tck), .TRST_N(trst_n),
        .TMS(tms), .TMS_DRIVEN(tms_drv), .TDI(tdi), .TDI_DRIVEN(tdi_drv),
        .TDO(tdo), .TDO_OE(tdo_oe), .CPU_ADDR(cpu_addr), .CPU_SIZE(cpu_size),
        .CPU_RD(cpu_rd), .CPU_WR(cpu_wr), .CPU_WDATA(cpu_wdata),
        .CPU_RDATA(cpu_rdata), .CPU_ACK(cpu_ack), .INTR_REQ(intr_req)
    );
    jtd_probe u_probe (
        .tck(tck), .trst_n(trst_n), .tms(tms), .tms_drv(tms_drv),
        .tdi(tdi), .tdi_drv(tdi_drv), .tdo(tdo), .tdo_oe(tdo_oe)
    );

    always #2 clk = ~clk;

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one-cycle request; the answer is fixed one cycle later, seen at mid-cycle
    task automatic cpu(input logic w, input logic [31:0] a, input jtd_size_e sz,
                       input logic [31:0] d, output logic [31:0] v);
        @(posedge clk);
        cpu_rd <= ~w;
        cpu_wr <= w;
        cpu_addr <= a;
        cpu_size <= sz;
        cpu_wdata <= d;
        @(posedge clk);
        cpu_rd <= 1'b0;
        cpu_wr <= 1'b0;
        @(negedge clk);
        check("cpu_ack", 32'h0000_0001, {31'h0, cpu_ack});
        v = cpu_rdata;
    endtask : cpu
    task automatic wr(input logic [31:0] a, input jtd_size_e sz, input logic [31:0] d);
        cpu(1'b1, a, sz, d, rd);
    endtask : wr
    task automatic rd_chk(input string what, input logic [31:0] a, input jtd_size_e sz,
                          input logic [31:0] exp);
        logic [31:0] v;
        cpu(1'b0, a, sz, 32'h0000_0000, v);
        check(what, exp, v);
    endtask : rd_chk
    // bounded wait; a request that never settles ends the run
    task automatic wait_intr(input logic v);
        int k;
        k = 0;
        while (intr_req !== v && k < 8) begin
            @(negedge clk);
            k++;
        end
        check("intr_req", {31'h0, v}, {31'h0, intr_req});
        if (intr_req !== v)
            conclude();
    endtask : wait_intr

    initial begin
        clk = 1'b0;
        reset = 1'b1;
        cpu_rd = 1'b0;
        cpu_wr = 1'b0;
        cpu_addr = 32'h0000_0000;
        cpu_size = SZ_WORD;
        cpu_wdata = 32'h0000_0000;
        err_total = 0;
        n_compared = 0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        u_probe.test_reset();
        repeat (3) @(posedge clk);
        foreach (rows[i])
            rd_chk("register read", rows[i].addr, rows[i].size, rows[i].exp);
        wr(32'hFFFF_FCB0, SZ_WORD, 32'h0000_1000);
        rd_chk("instruction after write", 32'hFFFF_FCB0, SZ_WORD, 32'h0000_E000);
        wr(32'hFFFF_FCB2, SZ_WORD, 32'h0000_0000);
        rd_chk("status flag cleared", 32'hFFFF_FCB2, SZ_WORD, 32'h0000_0700);
        wr(32'hFFFF_FCB3, SZ_BYTE, 32'h0000_0001);
        rd_chk("status byte write", 32'hFFFF_FCB2, SZ_WORD, 32'h0000_0701);
        wr(32'hFFFF_FCB2, SZ_WORD, 32'h0000_FFFF);
        rd_chk("status fixed bits", 32'hFFFF_FCB2, SZ_WORD, 32'h0000_0701);
        repeat (2) begin
            u_probe.scan(1'b0, 32, {340{1'b1}}, dout);
            check("id code", ID_VAL, dout[31:0]);
        end
        foreach (codes[i]) begin
            u_probe.scan(1'b1, 4, {336'h0, codes[i]}, dout);
            rd_chk("instruction", 32'hFFFF_FCB0, SZ_WORD, {16'h0000, codes[i], 12'h000});
            check("tdo_oe idle", 32'h0000_0000, {31'h0, tdo_oe});
            check("status shift", 32'h0000_0001, {30'h0, dout[1:0]});
        end
        u_probe.scan(1'b0, 8, {332'h0, 8'hB2}, dout);
        check("bypass path", {24'h00_0000, 8'hB2 << 1}, {24'h00_0000, dout[7:0]});
        u_probe.set_pins(1'b1, 1'b0);
        u_probe.scan(1'b0, 4, {340{1'b0}}, dout);
        u_probe.set_pins(1'b1, 1'b1);
        check("released data input", 32'h0000_000E, {28'h000_0000, dout[3:0]});
        u_probe.scan(1'b1, 6, {334'h0, 6'h2B}, dout);
        rd_chk("last four bits kept", 32'hFFFF_FCB0, SZ_WORD, 32'h0000_A000);
        wait_intr(1'b1);
        u_probe.scan(1'b0, 32, {308'h0, DATA_IN}, dout);
        repeat (4) @(posedge clk);
        rd_chk("serial data in", 32'hFFFF_FCB4, SZ_LONG, DATA_IN);
        rd_chk("flag after update", 32'hFFFF_FCB2, SZ_WORD, 32'h0000_0700);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rd_chk("instruction kept", 32'hFFFF_FCB0, SZ_WORD, 32'h0000_A000);
        rd_chk("data low kept", 32'hFFFF_FCB6, SZ_WORD, {16'h0000, DATA_IN[15:0]});
        wr(32'hFFFF_FCB4, SZ_LONG, DATA_OUT);
        u_probe.idle(4);
        u_probe.scan(1'b0, 32, {340{1'b0}}, dout);
        check("serial data out", DATA_OUT, dout[31:0]);
        u_probe.step(1'b1, 1'b0, q_bit);
        repeat (2) u_probe.step(1'b0, 1'b0, q_bit);
        repeat (8) @(posedge clk);
        rd_chk("flag in transfer", 32'hFFFF_FCB2, SZ_WORD, 32'h0000_0701);
        check("tdo_oe shifting", 32'h0000_0001, {31'h0, tdo_oe});
        u_probe.set_pins(1'b0, 1'b1);
        #1;
        check("tdo_oe in test reset", 32'h0000_0000, {31'h0, tdo_oe});
        wait_intr(1'b0);
        u_probe.test_reset();
        repeat (3) @(posedge clk);
        rd_chk("instruction test reset", 32'hFFFF_FCB0, SZ_WORD, 32'h0000_E000);
        u_probe.scan(1'b1, 4, {340{1'b0}}, dout);
        u_probe.scan(1'b0, 340, {330'h0, 10'h3A5}, dout);
        check("boundary length", 32'h0000_03A5, {22'h00_0000, dout[339:330]});
        conclude();
    end
endmodule : jtd_top_tb
